//--- verilog/wdtit_pkg.sv
// wdtit_pkg: constants and types of the watchdog / interval timer.
// assumes one 10 MHz system clock and a byte-wide cpu data port.
package wdtit_pkg;

  // register addresses on the cpu data port
  localparam logic [15:0] WDTIT_CLK_SEL_ADDR = 16'hFF42;
  localparam logic [15:0] WDTIT_MODE_ADDR = 16'hFFF9;

  // reset values
  localparam logic [7:0] WDTIT_CLK_SEL_RST = 8'h00;
  localparam logic [7:0] WDTIT_MODE_RST = 8'h00;
  localparam logic [7:0] WDTIT_UNMAPPED_DATA = 8'h00;

  // field positions
  localparam int WDTIT_RUN_BIT = 7;
  localparam int WDTIT_MODE_HI_BIT = 4;
  localparam int WDTIT_MODE_LO_BIT = 3;
  localparam int WDTIT_CLK_SEL_MSB = 2;

  // counter and prescaler widths
  localparam int WDTIT_CNT_W = 7;
  localparam int WDTIT_PRE_W = 10;
  localparam logic [6:0] WDTIT_CNT_MAX = 7'h7F;

  // count clock select codes
  localparam logic [2:0] WDTIT_SEL_DIV16 = 3'h0;
  localparam logic [2:0] WDTIT_SEL_DIV64 = 3'h2;
  localparam logic [2:0] WDTIT_SEL_DIV256 = 3'h4;
  localparam logic [2:0] WDTIT_SEL_DIV1024 = 3'h6;

  typedef enum logic [1:0] {
    WDTIT_MODE_STOP = 2'h0,
    WDTIT_MODE_INTERVAL = 2'h1,
    WDTIT_MODE_NMI = 2'h2,
    WDTIT_MODE_RESET = 2'h3
  } wdtit_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdtit_bus_t;

endpackage

//--- verilog/wdtit_prescaler.sv
// wdtit_prescaler: free-running divider of the system clock and count tick select.
// assumes clock select code is stable from the register file.
`timescale 1ns/1ps
module wdtit_prescaler (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic hold_in,
  input wire logic [2:0] clk_sel_in,
  output logic tick_out
);

  logic [wdtit_pkg::WDTIT_PRE_W-1:0] pre_q;
  logic [wdtit_pkg::WDTIT_PRE_W-1:0] pre_d;

  // never cleared by the run bit, hence the short first period
  always_comb begin
    pre_d = pre_q;
    if (!hold_in) begin
      pre_d = pre_q + 10'h001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_d;
    end
  end

  // prohibited codes give no tick at all
  always_comb begin
    tick_out = 1'b0;
    if (!hold_in) begin
      case (clk_sel_in)
        wdtit_pkg::WDTIT_SEL_DIV16: tick_out = &pre_q[3:0];
        wdtit_pkg::WDTIT_SEL_DIV64: tick_out = &pre_q[5:0];
        wdtit_pkg::WDTIT_SEL_DIV256: tick_out = &pre_q[7:0];
        wdtit_pkg::WDTIT_SEL_DIV1024: tick_out = &pre_q[9:0];
        default: tick_out = 1'b0;
      endcase
    end
  end

  // spacing only holds while fx/16 stays selected and stop standby does not freeze the divider
  property p_tick_div16;
    @(posedge ref_clk_in) disable iff (reset_in || hold_in || (clk_sel_in != wdtit_pkg::WDTIT_SEL_DIV16))
      tick_out |=> !tick_out [*8] ##8 tick_out;
  endproperty
  a_tick_div16: assert property (p_tick_div16) else $error("div16 tick spacing wrong");

endmodule // wdtit_prescaler

//--- verilog/wdtit_counter.sv
// wdtit_counter: 7-bit up counter that overflows after 128 count ticks.
// assumes tick and clear come from the same clock domain.
`timescale 1ns/1ps
module wdtit_counter (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic clear_in,
  input wire logic count_en_in,
  input wire logic tick_in,
  output logic [6:0] count_out,
  output logic ovf_out
);

  logic [wdtit_pkg::WDTIT_CNT_W-1:0] cnt_q;
  logic [wdtit_pkg::WDTIT_CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (clear_in) begin
      cnt_d = 7'h00;
    end else if (count_en_in && tick_in) begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count_out = cnt_q;
  // a clear in the overflow cycle wins: software kicked in time
  assign ovf_out = count_en_in && tick_in && !clear_in && (cnt_q == wdtit_pkg::WDTIT_CNT_MAX);

  property p_wrap;
    @(posedge ref_clk_in) disable iff (reset_in)
      ovf_out |=> (cnt_q == 7'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap after overflow");

endmodule // wdtit_counter

//--- verilog/wdtit_top.sv
// wdtit_top: watchdog / interval timer with clock select and mode registers.
// assumes a byte cpu data port on the system clock; flag, mask and stop come from same-clock logic.
`timescale 1ns/1ps
module wdtit_top (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire wdtit_pkg::wdtit_bus_t bus_in,
  input wire logic wdt_irq_flag_in,
  input wire logic wdt_irq_mask_in,
  input wire logic stop_mode_in,
  output logic [7:0] rd_data_out,
  output logic wdt_interval_irq_out,
  output logic wdt_irq_req_out,
  output logic wdt_irq_top_prio_out,
  output logic nmi_out,
  output logic sys_reset_req_out
);

  logic [2:0] clk_sel_q;
  logic [2:0] clk_sel_d;
  logic run_q;
  logic run_d;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  wdtit_pkg::wdtit_mode_t mode;
  logic wr_clk_sel;
  logic wr_mode;
  logic kick;
  logic count_en;
  logic tick;
  logic ovf;
  logic [6:0] count;
  logic nmi_on_select;

  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic interval_irq_q;
  logic interval_irq_d;
  logic irq_req_q;
  logic irq_req_d;
  logic prio_q;
  logic prio_d;
  logic nmi_q;
  logic nmi_d;
  logic sys_rst_q;
  logic sys_rst_d;

  // register file
  always_comb begin
    wr_clk_sel = bus_in.wr && (bus_in.addr == wdtit_pkg::WDTIT_CLK_SEL_ADDR);
    wr_mode = bus_in.wr && (bus_in.addr == wdtit_pkg::WDTIT_MODE_ADDR);
    kick = wr_mode && bus_in.wdata[wdtit_pkg::WDTIT_RUN_BIT];
    clk_sel_d = clk_sel_q;
    run_d = run_q;
    mode_d = mode_q;
    if (wr_clk_sel) begin
      clk_sel_d = bus_in.wdata[wdtit_pkg::WDTIT_CLK_SEL_MSB:0];
    end
    if (wr_mode) begin
      run_d = run_q | bus_in.wdata[wdtit_pkg::WDTIT_RUN_BIT];
      mode_d = mode_q | {bus_in.wdata[wdtit_pkg::WDTIT_MODE_HI_BIT],
                         bus_in.wdata[wdtit_pkg::WDTIT_MODE_LO_BIT]};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      clk_sel_q <= wdtit_pkg::WDTIT_CLK_SEL_RST[2:0];
      run_q <= wdtit_pkg::WDTIT_MODE_RST[wdtit_pkg::WDTIT_RUN_BIT];
      mode_q <= wdtit_pkg::WDTIT_MODE_RST[4:3];
    end else begin
      clk_sel_q <= clk_sel_d;
      run_q <= run_d;
      mode_q <= mode_d;
    end
  end

  assign mode = wdtit_pkg::wdtit_mode_t'(mode_q);
  // halt is not an input at all: the counter simply keeps going
  assign count_en = run_q && (mode != wdtit_pkg::WDTIT_MODE_STOP) && !stop_mode_in;

  wdtit_prescaler u_prescaler (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .hold_in(stop_mode_in),
    .clk_sel_in(clk_sel_q),
    .tick_out(tick)
  );

  // prescaler is not reset by a kick, so the first period loses up to one tick of 128
  wdtit_counter u_counter (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .clear_in(kick),
    .count_en_in(count_en),
    .tick_in(tick),
    .count_out(count),
    .ovf_out(ovf)
  );

  // a pending flag turns into an nmi the moment a watchdog mode is entered
  assign nmi_on_select = wr_mode && !mode_q[1] && bus_in.wdata[wdtit_pkg::WDTIT_MODE_HI_BIT]
                         && wdt_irq_flag_in;

  // outputs, all registered
  always_comb begin
    rd_data_d = wdtit_pkg::WDTIT_UNMAPPED_DATA;
    if (bus_in.rd && bus_in.addr == wdtit_pkg::WDTIT_CLK_SEL_ADDR) begin
      rd_data_d = {5'h00, clk_sel_q};
    end else if (bus_in.rd && bus_in.addr == wdtit_pkg::WDTIT_MODE_ADDR) begin
      rd_data_d = {run_q, 2'h0, mode_q, 3'h0};
    end
    interval_irq_d = ovf && (mode == wdtit_pkg::WDTIT_MODE_INTERVAL);
    irq_req_d = wdt_irq_flag_in && !wdt_irq_mask_in
                && (mode == wdtit_pkg::WDTIT_MODE_INTERVAL);
    prio_d = irq_req_d;
    nmi_d = (ovf && (mode == wdtit_pkg::WDTIT_MODE_NMI)) || nmi_on_select;
    sys_rst_d = ovf && (mode == wdtit_pkg::WDTIT_MODE_RESET);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rd_data_q <= 8'h00;
      interval_irq_q <= 1'b0;
      irq_req_q <= 1'b0;
      prio_q <= 1'b0;
      nmi_q <= 1'b0;
      sys_rst_q <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      interval_irq_q <= interval_irq_d;
      irq_req_q <= irq_req_d;
      prio_q <= prio_d;
      nmi_q <= nmi_d;
      sys_rst_q <= sys_rst_d;
    end
  end

  assign rd_data_out = rd_data_q;
  assign wdt_interval_irq_out = interval_irq_q;
  assign wdt_irq_req_out = irq_req_q;
  assign wdt_irq_top_prio_out = prio_q;
  assign nmi_out = nmi_q;
  assign sys_reset_req_out = sys_rst_q;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_kick;
    kick;
  endsequence

  sequence s_cleared;
    count == 7'h00;
  endsequence

  property p_kick_clears;
    s_kick |=> s_cleared;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("kick did not clear counter");

  property p_run_sticky;
    run_q |=> run_q;
  endproperty
  a_run_sticky: assert property (p_run_sticky) else $error("run bit dropped without reset");

  property p_mode_sticky;
    ##1 ((mode_q & $past(mode_q)) == $past(mode_q));
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) else $error("mode bit cleared by software");

  property p_reset_values;
    // own disable term: the module default would switch this check off exactly while reset is high
    @(posedge ref_clk_in) disable iff (1'b0) reset_in |=> (clk_sel_q == 3'h0 && mode_q == 2'h0 && !run_q);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("registers not cleared by reset");

  property p_interval_irq;
    (ovf && mode == wdtit_pkg::WDTIT_MODE_INTERVAL) |=> wdt_interval_irq_out ##1 !wdt_interval_irq_out;
  endproperty
  a_interval_irq: assert property (p_interval_irq) else $error("interval overflow gave no request");

  property p_overflow_action;
    (ovf && mode == wdtit_pkg::WDTIT_MODE_RESET) |=> (sys_reset_req_out && !nmi_out);
  endproperty
  a_overflow_action: assert property (p_overflow_action) else $error("reset mode overflow wrong");

  property p_nmi_select;
    nmi_on_select |=> nmi_out;
  endproperty
  a_nmi_select: assert property (p_nmi_select) else $error("pending flag gave no nmi");

  property p_stop_freeze;
    stop_mode_in |=> $stable(count) || $past(kick);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("counter moved in stop");

  property p_prio;
    wdt_irq_req_out |-> wdt_irq_top_prio_out;
  endproperty
  a_prio: assert property (p_prio) else $error("request without top priority");

  property p_masked;
    (wdt_irq_mask_in && !reset_in) |=> !wdt_irq_req_out;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request reached output");

  // read side: data shows the registers one cycle after the read strobe
  sequence s_read_clk_sel;
    bus_in.rd && (bus_in.addr == wdtit_pkg::WDTIT_CLK_SEL_ADDR);
  endsequence

  sequence s_read_mode;
    bus_in.rd && (bus_in.addr == wdtit_pkg::WDTIT_MODE_ADDR);
  endsequence

  property p_rd_clk_sel;
    s_read_clk_sel |=> (rd_data_out == {5'h00, $past(clk_sel_q)});
  endproperty
  a_rd_clk_sel: assert property (p_rd_clk_sel) else $error("clock select read back wrong");

  property p_rd_mode;
    s_read_mode |=> (((rd_data_out & 8'h67) == 8'h00) && (rd_data_out[7] == $past(run_q))
                    && (rd_data_out[4:3] == $past(mode_q)));
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode register read back wrong");

  property p_rd_idle;
    !bus_in.rd |=> (rd_data_out == wdtit_pkg::WDTIT_UNMAPPED_DATA);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle without a read");

  // write side: a written clock select code and any set run or mode bits land one cycle later
  property p_clk_sel_write;
    wr_clk_sel |=> ({5'h00, clk_sel_q} == ($past(bus_in.wdata) & 8'h07));
  endproperty
  a_clk_sel_write: assert property (p_clk_sel_write) else $error("clock select write lost");

  property p_run_set;
    s_kick |=> run_q;
  endproperty
  a_run_set: assert property (p_run_set) else $error("run bit not set by write");

  property p_mode_hi_set;
    (wr_mode && bus_in.wdata[wdtit_pkg::WDTIT_MODE_HI_BIT]) |=> mode_q[1];
  endproperty
  a_mode_hi_set: assert property (p_mode_hi_set) else $error("high mode bit not set");

  property p_mode_lo_set;
    (wr_mode && bus_in.wdata[wdtit_pkg::WDTIT_MODE_LO_BIT]) |=> mode_q[0];
  endproperty
  a_mode_lo_set: assert property (p_mode_lo_set) else $error("low mode bit not set");

  // counting: frozen unless enabled or kicked, one step per tick when enabled and not kicked
  property p_idle_freeze;
    !count_en |=> ($stable(count) || $past(kick));
  endproperty
  a_idle_freeze: assert property (p_idle_freeze) else $error("counter moved while disabled");

  property p_count_step;
    (count_en && tick && !kick) |=> (count == ($past(count) + 7'h01));
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step on tick");

  // every outgoing pulse traces back to an overflow in the matching mode, or for nmi to a pending flag at watchdog select
  property p_sysrst_source;
    sys_reset_req_out |-> ($past(ovf) && ($past(mode_q) == 2'h3));
  endproperty
  a_sysrst_source: assert property (p_sysrst_source) else $error("reset request without cause");

  property p_nmi_source;
    nmi_out |-> ($past(nmi_on_select) || ($past(ovf) && ($past(mode_q) == 2'h2)));
  endproperty
  a_nmi_source: assert property (p_nmi_source) else $error("nmi without cause");

  property p_iv_source;
    wdt_interval_irq_out |-> ($past(ovf) && ($past(mode_q) == 2'h1));
  endproperty
  a_iv_source: assert property (p_iv_source) else $error("interval pulse without cause");

  property p_sysrst_pulse;
    sys_reset_req_out |=> !sys_reset_req_out;
  endproperty
  a_sysrst_pulse: assert property (p_sysrst_pulse) else $error("reset request longer than one cycle");

  property p_req_unmasked;
    (wdt_irq_flag_in && !wdt_irq_mask_in && (mode == wdtit_pkg::WDTIT_MODE_INTERVAL)) |=> wdt_irq_req_out;
  endproperty
  a_req_unmasked: assert property (p_req_unmasked) else $error("unmasked flag gave no request");

endmodule // wdtit_top

//--- verification/wdtit_irq_model.sv
// wdtit_irq_model: interrupt controller side, holding the block's request flag and passing its mask straight through.
// assumes the bench presets, clears and masks the flag at falling clock edges.
`timescale 1ns/1ps
module wdtit_irq_model (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic irq_in,
  input wire logic ack_in,
  input wire logic force_in,
  input wire logic mask_in,
  output logic flag_out,
  output logic mask_out
);
  logic flag_q;
  // set wins over ack so an overflow pulse is never lost
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      flag_q <= 1'b0;
    end else if (irq_in || force_in) begin
      flag_q <= 1'b1;
    end else if (ack_in) begin
      flag_q <= 1'b0;
    end
  end
  assign flag_out = flag_q;
  assign mask_out = mask_in;
endmodule // wdtit_irq_model

//--- verification/wdtit_top_bench.sv
// wdtit_top_bench: self-checking bench of the watchdog / interval timer.
// assumes a 10 MHz clock; inputs change at falling edges only.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module wdtit_top_bench;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  wdtit_pkg::wdtit_bus_t bus = '0;
  logic stop = 1'b0, ack = 1'b0, frc = 1'b0, msk = 1'b1, flag, mask;
  logic [7:0] rd_data;
  logic iv_irq, req, prio, nmi, sysrst;
  int num_errors = 0, checks_done = 0, cyc = 0, n;
  localparam logic [15:0] CS = wdtit_pkg::WDTIT_CLK_SEL_ADDR;
  localparam logic [15:0] MD = wdtit_pkg::WDTIT_MODE_ADDR;
  always #50 ref_clk_in = ~ref_clk_in;
  wdtit_top DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .bus_in(bus), .wdt_irq_flag_in(flag),
    .wdt_irq_mask_in(mask), .stop_mode_in(stop), .rd_data_out(rd_data), .wdt_interval_irq_out(iv_irq),
    .wdt_irq_req_out(req), .wdt_irq_top_prio_out(prio), .nmi_out(nmi), .sys_reset_req_out(sysrst));
  wdtit_irq_model PARTNER (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .irq_in(iv_irq), .ack_in(ack),
    .force_in(frc), .mask_in(msk), .flag_out(flag), .mask_out(mask));
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // long enough for every period below plus margin
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  // whole-byte writes only
  // a fresh negedge first, so back-to-back calls never drive bus twice in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_in) bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge ref_clk_in) bus = '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge ref_clk_in) bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge ref_clk_in) bus = '0;
    `CHK(rd_data, e)
  endtask
  function automatic logic hit(input int w);
    return (w == 0) ? iv_irq === 1'b1 : (w == 1) ? nmi === 1'b1 : sysrst === 1'b1;
  endfunction
  task automatic wait_ev(input int w, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge ref_clk_in);
      cnt++;
    end while (cnt < lim && !hit(w));
  endtask
  task automatic pulse_rst();
    reset_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    reset_in = 1'b0;
  endtask
  task automatic t_reset();
    rd(CS, 8'h00);
    rd(MD, 8'h00);
    rd(16'h1234, 8'h00);
    wait_ev(0, 2200, n);
    `CHK(n, 2200)
  endtask
  task automatic t_clksel();
    wr(CS, 8'hFF);
    rd(CS, 8'h07);
    wr(CS, 8'h01);
    wr(MD, 8'h88);
    wait_ev(0, 4200, n);
    `CHK(n, 4200)
    wr(CS, 8'h00);
  endtask
  task automatic t_interval();
    wr(MD, 8'h88);
    wait_ev(0, 2100, n);
    `CHK(n >= 2031 && n <= 2052, 1'b1)
    msk = 1'b0;
    wait_ev(0, 2100, n);
    `CHK(n, 2048)
    repeat (3) @(negedge ref_clk_in);
    `CHK(req, 1'b1)
    `CHK(prio, 1'b1)
    msk = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    `CHK(req, 1'b0)
    ack = 1'b1;
    stop = 1'b1;
    @(negedge ref_clk_in) ack = 1'b0;
    wait_ev(0, 2500, n);
    `CHK(n, 2500)
    stop = 1'b0;
    wait_ev(0, 2100, n);
    `CHK(n <= 2048, 1'b1)
    wr(MD, 8'h00);
    rd(MD, 8'h88);
  endtask
  task automatic t_watchdog();
    frc = 1'b1;
    @(negedge ref_clk_in) frc = 1'b0;
    wr(MD, 8'h90);
    // nmi stands only in the cycle in which wr returns
    `CHK(nmi, 1'b1)
    ack = 1'b1;
    @(negedge ref_clk_in) ack = 1'b0;
    repeat (3) begin
      wait_ev(1, 1500, n);
      `CHK(n, 1500)
      wr(MD, 8'h90);
    end
    wait_ev(1, 2100, n);
    `CHK(n >= 2031 && n <= 2052, 1'b1)
    wr(CS, 8'h02);
    wr(MD, 8'h88);
    rd(MD, 8'h98);
    wait_ev(2, 8300, n);
    `CHK(n >= 8126 && n <= 8196, 1'b1)
    `CHK(flag, 1'b0)
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_in);
    reset_in = 1'b0;
    t_reset();
    t_clksel();
    t_interval();
    pulse_rst();
    t_watchdog();
    end_of_test();
  end
endmodule // wdtit_top_bench
